//--- hw/agc_param_pkg.sv
// Constants, field layouts and carrier types of the AGC parameter register bank
package agc_param_pkg;

    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] OFS_LEFT_GAIN = 8'h5D;  // Left applied gain readback
    localparam logic [7:0] OFS_CTRL_ONE = 8'h5E;   // Right enable, target, gain hysteresis
    localparam logic [7:0] OFS_CTRL_TWO = 8'h5F;   // Right level hysteresis, noise threshold
    localparam logic [7:0] OFS_MAX_GAIN = 8'h60;   // Right maximum gain
    localparam logic [7:0] OFS_ATTACK = 8'h61;     // Right attack time and scale

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int CTL1_EN_BIT = 7;
    localparam int CTL1_TGT_HI = 6;
    localparam int CTL1_TGT_LO = 4;
    localparam int CTL1_GHYS_HI = 1;
    localparam int CTL1_GHYS_LO = 0;
    localparam int CTL2_LHYS_HI = 7;
    localparam int CTL2_LHYS_LO = 6;
    localparam int CTL2_NOISE_HI = 5;
    localparam int CTL2_NOISE_LO = 1;
    localparam int MAXG_HI = 6;
    localparam int MAXG_LO = 0;
    localparam int ATK_BASE_HI = 7;
    localparam int ATK_BASE_LO = 3;
    localparam int ATK_SCALE_HI = 2;
    localparam int ATK_SCALE_LO = 0;

    // ****************************************************************
    // Reset values and reserved-bit masks
    // ****************************************************************
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] GAIN_RST = 8'h00;       // Applied gain 0.0 dB
    localparam logic [7:0] GAIN_MIN = 8'hE8;       // -12.0 dB floor of the gain code
    localparam logic [6:0] MAX_GAIN_RST = 7'h7F;   // 63.5 dB
    localparam logic [1:0] LHYS_OFF = 2'h3;        // Level hysteresis off code
    localparam logic [7:0] CTL1_RSVD = 8'h0C;
    localparam logic [7:0] CTL2_RSVD = 8'h01;
    localparam logic [7:0] MAXG_RSVD = 8'h80;

    // ****************************************************************
    // Attack time arithmetic, in ADC word clocks
    // ****************************************************************
    localparam int ATK_W = 18;                     // 63*32*128 fits in 18 bits
    localparam int ATK_UNIT_SHIFT = 5;             // Base unit of 32 word clocks
    localparam logic [ATK_W-1:0] ATK_ONE = 18'h00001;

    // ****************************************************************
    // Carrier types
    // ****************************************************************
    typedef struct packed {
        logic wr;                                  // Write strobe
        logic rd;                                  // Read strobe
        logic [7:0] addr;                          // Register offset
        logic [7:0] wdata;                         // Write data
    } reg_req_t;

    typedef struct packed {
        logic enable;
        logic [2:0] target;
        logic [1:0] gain_hyst;
        logic [1:0] level_hyst;
        logic [4:0] noise_thr;
        logic [6:0] max_gain;
        logic [4:0] atk_base;
        logic [2:0] atk_scale;
    } agc_cfg_t;

    // Effective attack time: (2n+1)*32 word clocks times 2^scale
    function automatic logic [ATK_W-1:0] attack_words(input logic [4:0] base,
                                                      input logic [2:0] scale);
        logic [ATK_W-1:0] odd;
        odd = {12'h000, base, 1'b1};
        return (odd << ATK_UNIT_SHIFT) << scale;
    endfunction

endpackage

//--- hw/agc_param_registers.sv
// AGC parameter register bank with gain limiter and attack timer
`timescale 1ns/10ps
`default_nettype none

module agc_param_registers
    import agc_param_pkg::*;
(
    input wire logic clk_sys_i,                    // 200 MHz system clock
    input wire logic rst_n_i,                      // Async reset, active low
    input wire reg_req_t reg_req_i,                // Register bus request
    output logic [7:0] rd_data_o,                  // Read data, cycle after strobe
    input wire logic [7:0] left_gain_i,            // Gain applied by left AGC engine
    input wire logic [7:0] right_gain_req_i,       // Gain asked by right AGC engine
    input wire logic word_clk_en_i,                // One pulse per ADC word clock
    output agc_cfg_t cfg_o,                        // Right AGC settings
    output logic [7:0] right_gain_o,               // Limited right applied gain
    output logic [ATK_W-1:0] attack_words_o,       // Effective attack, word clocks
    output logic attack_tick_o,                    // Pulse when an attack period ends
    output logic noise_gate_on_o                   // Noise gate active
);

    // ****************************************************************
    // Register state
    // ****************************************************************
    agc_cfg_t cfg_ff;
    agc_cfg_t nxt_cfg;
    logic [7:0] left_ff;
    logic [7:0] nxt_left;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;

    // ****************************************************************
    // Datapath state
    // ****************************************************************
    logic [7:0] gain_ff;
    logic [7:0] nxt_gain;
    logic [ATK_W-1:0] atk_words_ff;
    logic [ATK_W-1:0] nxt_atk_words;
    logic noise_ff;
    logic nxt_noise;
    logic [ATK_W-1:0] atk_cnt_ff;
    logic [ATK_W-1:0] nxt_atk_cnt;
    logic tick_ff;
    logic nxt_tick;

    // Read mux used only by the bus read path
    function automatic logic [7:0] read_value(input logic [7:0] addr,
                                              input agc_cfg_t c,
                                              input logic [7:0] left);
        logic [7:0] v;
        v = BYTE_ZERO;
        case (addr)
            OFS_LEFT_GAIN: begin
                v = left;
            end
            OFS_CTRL_ONE: begin
                v[CTL1_EN_BIT] = c.enable;
                v[CTL1_TGT_HI:CTL1_TGT_LO] = c.target;
                v[CTL1_GHYS_HI:CTL1_GHYS_LO] = c.gain_hyst;
            end
            OFS_CTRL_TWO: begin
                v[CTL2_LHYS_HI:CTL2_LHYS_LO] = c.level_hyst;
                v[CTL2_NOISE_HI:CTL2_NOISE_LO] = c.noise_thr;
            end
            OFS_MAX_GAIN: begin
                v[MAXG_HI:MAXG_LO] = c.max_gain;
            end
            OFS_ATTACK: begin
                v[ATK_BASE_HI:ATK_BASE_LO] = c.atk_base;
                v[ATK_SCALE_HI:ATK_SCALE_LO] = c.atk_scale;
            end
            default: begin
                v = BYTE_ZERO;
            end
        endcase
        return v;
    endfunction

    // ****************************************************************
    // Register file: write decode, readback capture, read data
    // ****************************************************************

    // Writes only touch defined fields, so stray reserved bits are dropped
    always_comb begin
        nxt_cfg = cfg_ff;
        nxt_left = left_gain_i;
        nxt_rdata = BYTE_ZERO;
        if (reg_req_i.wr) begin
            case (reg_req_i.addr)
                OFS_CTRL_ONE: begin
                    nxt_cfg.enable = reg_req_i.wdata[CTL1_EN_BIT];
                    nxt_cfg.target = reg_req_i.wdata[CTL1_TGT_HI:CTL1_TGT_LO];
                    nxt_cfg.gain_hyst = reg_req_i.wdata[CTL1_GHYS_HI:CTL1_GHYS_LO];
                end
                OFS_CTRL_TWO: begin
                    nxt_cfg.level_hyst = reg_req_i.wdata[CTL2_LHYS_HI:CTL2_LHYS_LO];
                    nxt_cfg.noise_thr = reg_req_i.wdata[CTL2_NOISE_HI:CTL2_NOISE_LO];
                end
                OFS_MAX_GAIN: begin
                    nxt_cfg.max_gain = reg_req_i.wdata[MAXG_HI:MAXG_LO];
                end
                OFS_ATTACK: begin
                    nxt_cfg.atk_base = reg_req_i.wdata[ATK_BASE_HI:ATK_BASE_LO];
                    nxt_cfg.atk_scale = reg_req_i.wdata[ATK_SCALE_HI:ATK_SCALE_LO];
                end
                default: begin
                    nxt_cfg = cfg_ff;              // Read-only or unmapped: ignored
                end
            endcase
        end
        if (reg_req_i.rd) begin
            nxt_rdata = read_value(reg_req_i.addr, cfg_ff, left_ff);
        end
    end

    // Read data holds for one cycle only, then returns to zero
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cfg_ff <= '{enable: 1'b0, target: 3'h0, gain_hyst: 2'h0, level_hyst: 2'h0,
                        noise_thr: 5'h00, max_gain: MAX_GAIN_RST, atk_base: 5'h00,
                        atk_scale: 3'h0};
            left_ff <= GAIN_RST;
            rdata_ff <= BYTE_ZERO;
        end else begin
            cfg_ff <= nxt_cfg;
            left_ff <= nxt_left;
            rdata_ff <= nxt_rdata;
        end
    end

    // ****************************************************************
    // Gain limiter and derived settings
    // ****************************************************************

    // Engine request is clamped to the programmed ceiling and the code floor;
    // a disabled channel sits at 0 dB rather than holding a stale gain
    always_comb begin
        nxt_gain = GAIN_RST;
        if (cfg_ff.enable) begin
            if ($signed(right_gain_req_i) > $signed({1'b0, cfg_ff.max_gain})) begin
                nxt_gain = {1'b0, cfg_ff.max_gain};
            end else if ($signed(right_gain_req_i) < $signed(GAIN_MIN)) begin
                nxt_gain = GAIN_MIN;
            end else begin
                nxt_gain = right_gain_req_i;
            end
        end
        nxt_atk_words = attack_words(cfg_ff.atk_base, cfg_ff.atk_scale);
        nxt_noise = cfg_ff.enable && (cfg_ff.noise_thr != 5'h00);
    end

    // Registered so every output comes straight from a flip-flop
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_ff <= GAIN_RST;
            atk_words_ff <= ATK_ONE << ATK_UNIT_SHIFT;
            noise_ff <= 1'b0;
        end else begin
            gain_ff <= nxt_gain;
            atk_words_ff <= nxt_atk_words;
            noise_ff <= nxt_noise;
        end
    end

    // ****************************************************************
    // Attack period timer, counted in ADC word clocks
    // ****************************************************************

    // A shortened setting takes effect at once: the count restarts when it
    // has already passed the new period instead of wrapping the full range
    always_comb begin
        nxt_atk_cnt = atk_cnt_ff;
        nxt_tick = 1'b0;
        if (!cfg_ff.enable) begin
            nxt_atk_cnt = '0;
        end else if (word_clk_en_i) begin
            if (atk_cnt_ff >= atk_words_ff - ATK_ONE) begin
                nxt_atk_cnt = '0;
                nxt_tick = 1'b1;
            end else begin
                nxt_atk_cnt = atk_cnt_ff + ATK_ONE;
            end
        end
    end

    // Tick is a single-cycle pulse
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            atk_cnt_ff <= '0;
            tick_ff <= 1'b0;
        end else begin
            atk_cnt_ff <= nxt_atk_cnt;
            tick_ff <= nxt_tick;
        end
    end

    // Outputs
    assign rd_data_o = rdata_ff;
    assign cfg_o = cfg_ff;
    assign right_gain_o = gain_ff;
    assign attack_words_o = atk_words_ff;
    assign attack_tick_o = tick_ff;
    assign noise_gate_on_o = noise_ff;

    // ****************************************************************
    // Checks
    // ****************************************************************

    left_readback_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.rd && reg_req_i.addr == OFS_LEFT_GAIN |=> rd_data_o == $past(left_ff))
        else $error("left gain readback mismatch");

    enable_write_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.wr && reg_req_i.addr == OFS_CTRL_ONE
        |=> cfg_o.enable == $past(reg_req_i.wdata[CTL1_EN_BIT]))
        else $error("enable bit not written");

    ctrl_one_read_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.wr && reg_req_i.addr == OFS_CTRL_ONE ##1
        reg_req_i.rd && reg_req_i.addr == OFS_CTRL_ONE
        |=> rd_data_o == ($past(reg_req_i.wdata, 2) & ~CTL1_RSVD))
        else $error("control one readback wrong");

    gain_hyst_field_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.wr && reg_req_i.addr == OFS_CTRL_ONE
        |=> cfg_o.gain_hyst == $past(reg_req_i.wdata[CTL1_GHYS_HI:CTL1_GHYS_LO]))
        else $error("gain hysteresis field wrong");

    level_hyst_hold_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !(reg_req_i.wr && reg_req_i.addr == OFS_CTRL_TWO) |=> $stable(cfg_o.level_hyst))
        else $error("level hysteresis changed without write");

    noise_gate_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        noise_gate_on_o == $past(cfg_ff.enable && cfg_ff.noise_thr != 5'h00))
        else $error("noise gate state wrong");

    max_gain_read_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.rd && reg_req_i.addr == OFS_MAX_GAIN
        |=> rd_data_o == {1'b0, $past(cfg_ff.max_gain)})
        else $error("max gain readback wrong");

    attack_tick_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        attack_tick_o |-> $past(word_clk_en_i) && $past(cfg_ff.enable))
        else $error("attack tick without word clock");

    attack_scale_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.wr && reg_req_i.addr == OFS_ATTACK ##1 !reg_req_i.wr[*1]
        |=> attack_words_o == attack_words($past(reg_req_i.wdata[ATK_BASE_HI:ATK_BASE_LO], 2),
                                           $past(reg_req_i.wdata[ATK_SCALE_HI:ATK_SCALE_LO], 2)))
        else $error("effective attack time wrong");

    // Each register is masked with its own reserved bits only; a shared mask
    // would hit live fields such as the enable bit
    reserved_zero_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(reg_req_i.rd)
        |-> ($past(reg_req_i.addr) != OFS_CTRL_ONE || (rd_data_o & CTL1_RSVD) == BYTE_ZERO)
        && ($past(reg_req_i.addr) != OFS_CTRL_TWO || (rd_data_o & CTL2_RSVD) == BYTE_ZERO)
        && ($past(reg_req_i.addr) != OFS_MAX_GAIN || (rd_data_o & MAXG_RSVD) == BYTE_ZERO))
        else $error("reserved bits read nonzero");

    gain_ceiling_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $past(cfg_ff.enable) |-> $signed(right_gain_o) <= $signed({1'b0, $past(cfg_ff.max_gain)}))
        else $error("applied gain above maximum");

    // Large cuts from the engine must stay inside the signed code range
    gain_floor_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $signed(right_gain_o) >= $signed(GAIN_MIN))
        else $error("applied gain below code floor");

    // A disabled channel must not pass the engine request to the output
    disabled_gain_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        !$past(cfg_ff.enable) |-> right_gain_o == GAIN_RST)
        else $error("gain applied while disabled");

    unmapped_read_a: assert property (
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        reg_req_i.rd && (reg_req_i.addr < OFS_LEFT_GAIN || reg_req_i.addr > OFS_ATTACK)
        |=> rd_data_o == BYTE_ZERO)
        else $error("unmapped read nonzero");

endmodule

`default_nettype wire

//--- testbench/tb_agc_param_registers.sv
// Self-checking bench for the AGC parameter register bank
`timescale 1ns/10ps
`default_nettype none

module tb_agc_param_registers
    import agc_param_pkg::*;
;
    logic clk_sys_i;
    logic rst_n_i;
    reg_req_t reg_req_i;
    logic [7:0] rd_data_o;
    logic [7:0] left_gain_i;
    logic [7:0] right_gain_req_i;
    logic word_clk_en_i;
    agc_cfg_t cfg_o;
    logic [7:0] right_gain_o;
    logic [ATK_W-1:0] attack_words_o;
    logic attack_tick_o;
    logic noise_gate_on_o;
    int miscompares = 0;
    int checks = 0;
    int cycles = 0;
    int ticks = 0;

    agc_param_registers i_agc_param_registers (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .reg_req_i(reg_req_i),
        .rd_data_o(rd_data_o),
        .left_gain_i(left_gain_i),
        .right_gain_req_i(right_gain_req_i),
        .word_clk_en_i(word_clk_en_i),
        .cfg_o(cfg_o),
        .right_gain_o(right_gain_o),
        .attack_words_o(attack_words_o),
        .attack_tick_o(attack_tick_o),
        .noise_gate_on_o(noise_gate_on_o)
    );

    // ****************************************************************
    // Clock, tick counter and hang guard
    // ****************************************************************
    initial begin
        clk_sys_i = 1'b0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // Whole run needs well under 3000 cycles, so 5000 means a hang
    always @(posedge clk_sys_i) begin
        cycles++;
        if (attack_tick_o === 1'b1) ticks++;
        if (cycles == 5000) begin
            miscompares++;
            results();
        end
    end

    // ****************************************************************
    // Bus and compare tasks
    // ****************************************************************
    task automatic chk(input logic [17:0] got, input logic [17:0] exp);
        checks++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; a gap cycle follows so strobes never merge
    task automatic wr_reg(input logic [7:0] addr, input logic [7:0] data);
        @(posedge clk_sys_i);
        reg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys_i);
        reg_req_i <= '0;
    endtask

    // Read data stands only in the cycle after the strobe, sampled there
    task automatic rd_chk(input logic [7:0] addr, input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_sys_i);
        reg_req_i <= '0;
        #1;
        chk({10'h000, rd_data_o}, {10'h000, exp});
    endtask

    // Write then read with no idle cycle, as the bus allows
    task automatic wr_rd_chk(input logic [7:0] addr, input logic [7:0] data,
                             input logic [7:0] exp);
        @(posedge clk_sys_i);
        reg_req_i <= '{wr: 1'b1, rd: 1'b0, addr: addr, wdata: data};
        @(posedge clk_sys_i);
        reg_req_i <= '{wr: 1'b0, rd: 1'b1, addr: addr, wdata: 8'h00};
        @(posedge clk_sys_i);
        reg_req_i <= '0;
        #1;
        chk({10'h000, rd_data_o}, {10'h000, exp});
    endtask

    // Let derived outputs settle two edges after a write
    task automatic settle();
        repeat (2) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            word_clk_en_i <= 1'b1;
        end
        @(posedge clk_sys_i);
        word_clk_en_i <= 1'b0;
        repeat (3) @(posedge clk_sys_i);
    endtask

    task automatic results();
        $display("Counts: %0d checks, %0d miscompares", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // ****************************************************************
    // Test sequence
    // ****************************************************************
    initial begin
        int exp_w;
        static logic [7:0] gain_tab [5] = '{8'h20, 8'h05, 8'h80, 8'hF0, 8'h10};
        static logic [7:0] gain_exp [5] = '{8'h10, 8'h05, 8'hE8, 8'hF0, 8'h10};
        static logic [7:0] atk_tab [4] = '{8'h00, 8'h09, 8'hFF, 8'h2A};
        rst_n_i = 1'b0;
        reg_req_i = '0;
        left_gain_i = 8'h00;
        right_gain_req_i = 8'h00;
        word_clk_en_i = 1'b0;
        // Reset state
        repeat (10) @(posedge clk_sys_i);
        #1;
        chk(cfg_o.max_gain, 8'h7F);
        chk(cfg_o.enable, 8'h00);
        chk(attack_words_o, 18'h00020);
        chk(right_gain_o, 8'h00);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd_chk(OFS_LEFT_GAIN, 8'h00);
        rd_chk(OFS_CTRL_ONE, 8'h00);
        rd_chk(OFS_CTRL_TWO, 8'h00);
        rd_chk(OFS_MAX_GAIN, 8'h7F);
        rd_chk(OFS_ATTACK, 8'h00);
        rd_chk(8'h5C, 8'h00);
        $display("Test reset values done");
        // Left readback, extremes of the gain code, write ignored
        @(posedge clk_sys_i);
        left_gain_i <= 8'hE8;
        rd_chk(OFS_LEFT_GAIN, 8'hE8);
        @(posedge clk_sys_i);
        left_gain_i <= 8'h7F;
        wr_reg(OFS_LEFT_GAIN, 8'h11);
        rd_chk(OFS_LEFT_GAIN, 8'h7F);
        $display("Test left readback done");
        // Reserved positions drop on write and read zero
        wr_reg(OFS_CTRL_ONE, 8'hFF);
        rd_chk(OFS_CTRL_ONE, 8'hF3);
        wr_reg(OFS_CTRL_TWO, 8'hFF);
        rd_chk(OFS_CTRL_TWO, 8'hFE);
        wr_reg(OFS_MAX_GAIN, 8'hFF);
        rd_chk(OFS_MAX_GAIN, 8'h7F);
        wr_rd_chk(OFS_CTRL_ONE, 8'hAF, 8'hA3);
        wr_rd_chk(OFS_ATTACK, 8'h2A, 8'h2A);
        $display("Test reserved bits done");
        // Every target and gain hysteresis code
        for (int t = 0; t < 8; t++) begin
            wr_reg(OFS_CTRL_ONE, {1'b1, t[2:0], 2'b00, t[1:0]});
            rd_chk(OFS_CTRL_ONE, {1'b1, t[2:0], 2'b00, t[1:0]});
            chk(cfg_o.target, t[2:0]);
            chk(cfg_o.gain_hyst, t[1:0]);
            chk(cfg_o.enable, 8'h01);
        end
        // Every level hysteresis code beside a full noise field
        for (int h = 0; h < 4; h++) begin
            wr_reg(OFS_CTRL_TWO, {h[1:0], 5'h1F, 1'b0});
            rd_chk(OFS_CTRL_TWO, {h[1:0], 5'h1F, 1'b0});
            chk(cfg_o.level_hyst, h[1:0]);
            chk(cfg_o.noise_thr, 8'h1F);
        end
        $display("Test field codes done");
        // Noise gate: code zero disables, nonzero arms it
        wr_reg(OFS_CTRL_TWO, 8'h00);
        settle();
        chk(noise_gate_on_o, 8'h00);
        wr_reg(OFS_CTRL_TWO, 8'h02);
        settle();
        chk(noise_gate_on_o, 8'h01);
        $display("Test noise gate done");
        // Gain limiter against a 8.0 dB maximum
        wr_reg(OFS_MAX_GAIN, 8'h10);
        rd_chk(OFS_MAX_GAIN, 8'h10);
        for (int i = 0; i < 5; i++) begin
            @(posedge clk_sys_i);
            right_gain_req_i <= gain_tab[i];
            settle();
            chk(right_gain_o, gain_exp[i]);
        end
        wr_reg(OFS_MAX_GAIN, 8'h00);
        settle();
        chk(right_gain_o, 8'h00);
        $display("Test gain limit done");
        // Effective attack length for base and scale pairs
        for (int i = 0; i < 4; i++) begin
            wr_reg(OFS_ATTACK, atk_tab[i]);
            rd_chk(OFS_ATTACK, atk_tab[i]);
            exp_w = (2 * atk_tab[i][7:3] + 1) * 32 * (2 ** atk_tab[i][2:0]);
            settle();
            chk(attack_words_o, exp_w[17:0]);
        end
        $display("Test attack length done");
        // Attack ticks: 32 and 64 word clocks, and clear on disable
        wr_reg(OFS_ATTACK, 8'h00);
        settle();
        ticks = 0;
        pulses(96);
        chk(ticks, 18'h00003);
        wr_reg(OFS_ATTACK, 8'h01);
        settle();
        ticks = 0;
        pulses(128);
        chk(ticks, 18'h00002);
        wr_reg(OFS_ATTACK, 8'h00);
        ticks = 0;
        pulses(20);
        wr_reg(OFS_CTRL_ONE, 8'h00);
        wr_reg(OFS_CTRL_ONE, 8'h80);
        pulses(20);
        chk(ticks, 18'h00000);
        wr_reg(OFS_CTRL_ONE, 8'h00);
        settle();
        chk(noise_gate_on_o, 8'h00);
        $display("Test attack timer done");
        results();
    end

endmodule

`default_nettype wire
